// file: design/channel_filter.sv
`timescale 1ns/100ps
`default_nettype none

module channel_filter
	import torque_off_pkg::*;
#(
	parameter int LOW_TICKS = FILTER_TICKS
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_tick,
	input  wire logic i_pin,
	output logic      o_sync,
	output logic      o_level
);

	chan_state_type q;
	chan_state_type d;

	always_comb begin
		d = q;
		d.meta = i_pin;
		d.sync = q.meta;
		if (q.sync) begin
			// high releases at once; only low needs proof
			d.level   = 1'b1;
			d.low_cnt = FILTER_RESET;
		end else if (q.level && i_tick) begin
			if (q.low_cnt >= FILTER_W'(LOW_TICKS - 1)) begin
				d.level   = 1'b0; // [R1] [R2]
				d.low_cnt = FILTER_RESET;
			end else begin
				d.low_cnt = q.low_cnt + FILTER_W'(1); // [R10]
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			q <= '{meta: 1'b0, sync: 1'b0, level: 1'b0, low_cnt: FILTER_RESET};
		end else begin
			q <= d;
		end
	end

	assign o_sync  = q.sync;
	assign o_level = q.level;

endmodule

`default_nettype wire

// file: design/tick_divider.sv
`timescale 1ns/100ps
`default_nettype none

module tick_divider
	import torque_off_pkg::*;
#(
	parameter int CYCLES = TICK_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	output logic      o_tick
);

	tick_state_type q;
	tick_state_type d;

	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (q.count == TICK_W'(CYCLES - 1)) begin
			d.count = TICK_RESET;
			d.tick  = 1'b1;
		end else begin
			d.count = q.count + TICK_W'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			q <= '{count: TICK_RESET, tick: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign o_tick = q.tick;

endmodule

`default_nettype wire

// file: design/torque_off_monitor.sv
// Contract
// [R1] channel A low or open requests torque off and stops the drive.
// [R2] channel B low or open does the same, independent of channel A.
// [R3] both channels high release the power stage to software control.
// [R4] any torque off blocks start and power and reports a trip.
// [R5] one requesting channel alone removes torque within 15 ms.
// [R6] channels unequal over one second may latch the fault state.
// [R7] channels unequal over five seconds must latch the fault state.
// [R8] latched fault holds until power cycle; input changes never clear it.
// [R9] energy is removed within 15 ms of a torque off request.
// [R10] external controller keeps low test pulses at most 1.5 ms.
// [R11] detected internal failure applies torque off automatically.
// [R12] the two channels stay independent against a single failure.
// [R13] trips report code 31; unacknowledgeable trip marks a defect.
// [R14] torque off overrides every start command, software only reports.
// [R15] disagreement timer runs only while channels differ, else restarts.
`timescale 1ns/100ps
`default_nettype none

module torque_off_monitor
	import torque_off_pkg::*;
#(
	parameter int TICK_CYCLES_P   = TICK_CYCLES,
	parameter int FILTER_TICKS_P  = FILTER_TICKS,
	parameter int LATCH_TICKS_P   = FAULT_LATCH_TICKS
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_torque_off_input_a,
	input  wire logic i_torque_off_input_b,
	input  wire logic i_internal_fault,
	input  wire logic i_run_request,
	input  wire logic i_trip_ack,
	output status_type o_status
);

	// ----------------------------------------
	// time base and channel conditioning
	// ----------------------------------------
	logic                tick;
	logic [CHANNELS-1:0] pins;
	logic [CHANNELS-1:0] chan_sync;
	logic [CHANNELS-1:0] chan_level;

	assign pins = {i_torque_off_input_b, i_torque_off_input_a};

	tick_divider #(
		.CYCLES(TICK_CYCLES_P)
	) u_tick (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.o_tick(tick)
	);

	// separate filters so a stuck path cannot mask the other one
	for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
		channel_filter #(
			.LOW_TICKS(FILTER_TICKS_P)
		) u_filter (
			.i_clk  (i_clk),
			.i_rst  (i_rst),
			.i_tick (tick),
			.i_pin  (pins[ch]),
			.o_sync (chan_sync[ch]),
			.o_level(chan_level[ch])
		); // [R12]
	end

	// ----------------------------------------
	// monitor state
	// ----------------------------------------
	top_state_type q;
	top_state_type d;

	logic differ;
	logic fault_now;
	logic a_ok;
	logic b_ok;

	always_comb begin
		d         = q;
		d.fault_meta = i_internal_fault;
		d.fault_sync = q.fault_meta;
		differ    = chan_sync[0] ^ chan_sync[1];
		fault_now = 1'b0;

		if (q.mode != MODE_FAULT) begin
			if (!differ) begin
				d.mismatch_ticks = TIMER_RESET; // [R15]
			end else if (tick && q.mismatch_ticks <= TIMER_W'(LATCH_TICKS_P)) begin
				d.mismatch_ticks = q.mismatch_ticks + TIMER_W'(1); // [R15]
			end
		end

		// latch once the count is past the limit: after 1 s, long before 5 s
		if (q.mode == MODE_FAULT || q.fault_sync ||
			q.mismatch_ticks > TIMER_W'(LATCH_TICKS_P)) begin
			fault_now = 1'b1; // [R6] [R7] [R11]
		end

		a_ok = chan_level[0] && !fault_now; // [R1] [R12]
		b_ok = chan_level[1] && !fault_now; // [R2] [R12]

		unique case (q.mode)
			MODE_FAULT: d.mode = MODE_FAULT; // [R8]
			MODE_RUN,
			MODE_OFF: begin
				if (fault_now) begin
					d.mode = MODE_FAULT;
				end else if (a_ok && b_ok) begin
					d.mode = MODE_RUN; // [R3]
				end else begin
					d.mode = MODE_OFF; // [R5] [R9]
				end
			end
			default: d.mode = MODE_FAULT;
		endcase

		d.status.power_enable_a      = a_ok;
		d.status.power_enable_b      = b_ok;
		d.status.safe_torque_removal = !(a_ok && b_ok); // [R4]
		// software start can never bypass the two enables
		d.status.run_enable          = a_ok && b_ok && i_run_request; // [R14]
		d.status.fault_latched       = (d.mode == MODE_FAULT); // [R8]
		d.status.mismatch            = differ;
		d.status.ack_refused         = 1'b0;

		// set wins over acknowledge
		if (!(a_ok && b_ok)) begin
			d.status.trip = 1'b1; // [R4] [R13]
			if (i_trip_ack) begin
				d.status.ack_refused = 1'b1; // [R13]
			end
		end else if (i_trip_ack) begin
			d.status.trip = 1'b0; // [R13]
		end
		d.status.trip_code = d.status.trip ? TRIP_CODE : NO_TRIP_CODE; // [R13]
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			q.mode           <= MODE_OFF;
			q.mismatch_ticks <= TIMER_RESET;
			q.fault_meta     <= 1'b0;
			q.fault_sync     <= 1'b0;
			q.status         <= '{power_enable_a: 1'b0, power_enable_b: 1'b0, run_enable: 1'b0,
				safe_torque_removal: 1'b1, trip: 1'b1, trip_code: TRIP_CODE,
				fault_latched: 1'b0, mismatch: 1'b0, ack_refused: 1'b0};
		end else begin
			q <= d;
		end
	end

	assign o_status = q.status;

endmodule

`default_nettype wire

// file: design/torque_off_pkg.sv
package torque_off_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS     = 40;
	localparam int TICK_TIME_NS      = 100000;
	localparam int TICK_CYCLES       = TICK_TIME_NS / CLK_PERIOD_NS;
	localparam int TEST_PULSE_MAX_US = 1500;
	// low filter must outlast the longest test pulse and stay far below the response limit
	localparam int FILTER_TIME_US    = 2000;
	localparam int FILTER_TICKS      = (FILTER_TIME_US * 1000 + TICK_TIME_NS - 1) / TICK_TIME_NS;
	localparam int RESPONSE_MAX_US   = 15000;
	localparam int FAULT_MAY_MS      = 1000;
	localparam int FAULT_MUST_MS     = 5000;
	// latch just past the earliest allowed point, well inside the latest
	localparam int FAULT_LATCH_TICKS = (FAULT_MAY_MS * 1000) / (TICK_TIME_NS / 1000);

	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int TICK_W   = 16;
	localparam int FILTER_W = 8;
	localparam int TIMER_W  = 16;
	localparam int CHANNELS = 2;

	localparam logic [7:0]         TRIP_CODE      = 8'h1f;
	localparam logic [7:0]         NO_TRIP_CODE   = 8'h00;
	localparam logic [TICK_W-1:0]  TICK_RESET     = 16'h0000;
	localparam logic [FILTER_W-1:0] FILTER_RESET  = 8'h00;
	localparam logic [TIMER_W-1:0] TIMER_RESET    = 16'h0000;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_OFF   = 3'b001,
		MODE_RUN   = 3'b010,
		MODE_FAULT = 3'b100
	} mode_type;

	typedef struct packed {
		logic [TICK_W-1:0] count;
		logic              tick;
	} tick_state_type;

	typedef struct packed {
		logic                meta;
		logic                sync;
		logic                level;
		logic [FILTER_W-1:0] low_cnt;
	} chan_state_type;

	typedef struct packed {
		logic       power_enable_a;
		logic       power_enable_b;
		logic       run_enable;
		logic       safe_torque_removal;
		logic       trip;
		logic [7:0] trip_code;
		logic       fault_latched;
		logic       mismatch;
		logic       ack_refused;
	} status_type;

	typedef struct packed {
		mode_type           mode;
		logic [TIMER_W-1:0] mismatch_ticks;
		logic               fault_meta;
		logic               fault_sync;
		status_type         status;
	} top_state_type;

endpackage

// file: tb/safety_unit_model.sv
`timescale 1ns/100ps
`default_nettype none

module safety_unit_model #(
	parameter int PULSE = 6
) (
	input  wire logic i_clk,
	input  wire logic i_en_a,
	input  wire logic i_en_b,
	input  wire logic i_pulse,
	output logic      o_a,
	output logic      o_b
);
	// self-test pulse kept shorter than the monitor's low filter
	int cnt_q = 0;
	always @(posedge i_clk) begin
		if (i_pulse && cnt_q == 0) begin
			cnt_q <= PULSE;
		end else if (cnt_q != 0) begin
			cnt_q <= cnt_q - 1;
		end
	end
	// lines are always driven, an open output reads low
	assign o_a = i_en_a && cnt_q == 0;
	assign o_b = i_en_b && cnt_q == 0;
endmodule
`default_nettype wire

// file: tb/torque_off_monitor_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module torque_off_monitor_assertions
	import torque_off_pkg::*;
#(
	parameter int TICK_CYCLES_P  = TICK_CYCLES,
	parameter int FILTER_TICKS_P = FILTER_TICKS,
	parameter int LATCH_TICKS_P  = FAULT_LATCH_TICKS
) (
	input wire logic       i_clk,
	input wire logic       i_rst,
	input wire logic       i_torque_off_input_a,
	input wire logic       i_torque_off_input_b,
	input wire logic       i_internal_fault,
	input wire logic       i_run_request,
	input wire logic       i_trip_ack,
	input wire status_type o_status
);
	// ----------------
	// helpers
	// ----------------
	// slack of a few cycles covers sync stages and tick phase
	localparam int LOW_LIM  = (FILTER_TICKS_P + 1) * TICK_CYCLES_P + 4;
	localparam int MAY_LIM  = LATCH_TICKS_P * TICK_CYCLES_P - 4;
	localparam int MUST_LIM = (LATCH_TICKS_P + 2) * TICK_CYCLES_P + 6;
	wire pa = o_status.power_enable_a;
	wire pb = o_status.power_enable_b;
	wire fl = o_status.fault_latched;
	int lo_a_q;
	int lo_b_q;
	int diff_q;
	always_ff @(posedge i_clk) begin
		lo_a_q <= (i_rst || i_torque_off_input_a) ? 0 : lo_a_q + 1;
		lo_b_q <= (i_rst || i_torque_off_input_b) ? 0 : lo_b_q + 1;
		diff_q <= (i_rst || i_torque_off_input_a == i_torque_off_input_b) ? 0 : diff_q + 1;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// ----------------
	// properties
	// ----------------
	property p_lo_a; lo_a_q > LOW_LIM |-> !pa; endproperty
	a_lo_a: assert property (p_lo_a) else $error("a low, power on");
	property p_lo_b; lo_b_q > LOW_LIM |-> !pb; endproperty
	a_lo_b: assert property (p_lo_b) else $error("b low, power on");
	property p_rel; (i_torque_off_input_a && i_torque_off_input_b && !fl && !i_internal_fault)[*5] |-> pa && pb; endproperty
	a_rel: assert property (p_rel) else $error("power not released");
	property p_str; !(pa && pb) |-> o_status.safe_torque_removal && o_status.trip; endproperty
	a_str: assert property (p_str) else $error("torque off not reported");
	property p_code; o_status.trip_code == (o_status.trip ? TRIP_CODE : NO_TRIP_CODE); endproperty
	a_code: assert property (p_code) else $error("bad trip code");
	property p_ack; $fell(o_status.trip) |-> $past(i_trip_ack) && pa && pb; endproperty
	a_ack: assert property (p_ack) else $error("trip cleared wrongly");
	property p_hold; $past(fl) |-> fl && !pa && !pb; endproperty
	a_hold: assert property (p_hold) else $error("fault released");
	property p_intf; i_internal_fault[*3] |=> fl; endproperty
	a_intf: assert property (p_intf) else $error("internal fault ignored");
	property p_must; diff_q > MUST_LIM |-> fl; endproperty
	a_must: assert property (p_must) else $error("fault not latched");
	property p_may; $rose(fl) |-> diff_q >= MAY_LIM || $past(i_internal_fault, 3); endproperty
	a_may: assert property (p_may) else $error("fault latched early");
	property p_run; o_status.run_enable |-> $past(i_run_request) && !$past(fl); endproperty
	a_run: assert property (p_run) else $error("run without request");
	c_run: cover property (pa && pb && o_status.run_enable);
	c_mismatch: cover property ($rose(o_status.mismatch));
	c_fault: cover property ($rose(fl));
	c_refuse: cover property (o_status.ack_refused);
endmodule

bind torque_off_monitor torque_off_monitor_assertions #(
	.TICK_CYCLES_P  (TICK_CYCLES_P),
	.FILTER_TICKS_P (FILTER_TICKS_P),
	.LATCH_TICKS_P  (LATCH_TICKS_P)
) i_checker (
	.i_clk(i_clk),
	.i_rst(i_rst),
	.i_torque_off_input_a(i_torque_off_input_a),
	.i_torque_off_input_b(i_torque_off_input_b),
	.i_internal_fault(i_internal_fault),
	.i_run_request(i_run_request),
	.i_trip_ack(i_trip_ack),
	.o_status(o_status)
);
`default_nettype wire

// file: tb/torque_off_monitor_tb.sv
`timescale 1ns/100ps
`default_nettype none

module torque_off_monitor_tb
	import torque_off_pkg::*;
;
	localparam int T = 4;
	localparam int F = 3;
	localparam int L = 20;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic en_a = 1'b0, en_b = 1'b0, pulse = 1'b0, flt = 1'b0, run = 1'b0, ack = 1'b0;
	logic pin_a, pin_b;
	status_type st;
	int miscompares = 0;
	int compares = 0;
	always #20 i_clk = ~i_clk;
	safety_unit_model i_safety_unit_model (.i_clk(i_clk), .i_en_a(en_a), .i_en_b(en_b), .i_pulse(pulse),
		.o_a(pin_a), .o_b(pin_b));
	torque_off_monitor #(.TICK_CYCLES_P(T), .FILTER_TICKS_P(F), .LATCH_TICKS_P(L)) i_torque_off_monitor (
		.i_clk(i_clk), .i_rst(i_rst), .i_torque_off_input_a(pin_a), .i_torque_off_input_b(pin_b),
		.i_internal_fault(flt), .i_run_request(run), .i_trip_ack(ack), .o_status(st));
	// ----------------
	// helpers
	// ----------------
	task automatic summarize();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: flag %b", $time, got);
		end
	endtask
	task automatic chk_code(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: code %h", $time, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic ack_pulse();
		ack = 1'b1;
		cyc(1);
		ack = 1'b0;
	endtask
	// ----------------
	// scenarios
	// ----------------
	logic timed_out = 1'b0;
	task automatic t_run();
		chk_code(st.trip_code, TRIP_CODE);
		chk_bit(st.safe_torque_removal, 1'b1);
		en_a = 1'b1;
		en_b = 1'b1;
		cyc(5);
		chk_bit(st.power_enable_a && st.power_enable_b, 1'b1);
		ack_pulse();
		chk_code(st.trip_code, NO_TRIP_CODE);
		run = 1'b1;
		cyc(2);
		chk_bit(st.run_enable, 1'b1);
		pulse = 1'b1;
		cyc(1);
		pulse = 1'b0;
		cyc(F * T + 8);
		chk_bit(st.power_enable_a, 1'b1);
		// trip is sticky, so a clear trip here shows the test pulse caused no dip
		chk_bit(st.trip, 1'b0);
	endtask
	// one channel drops, then returns before the disagreement limit
	task automatic t_single(input logic is_b);
		en_a = is_b;
		en_b = !is_b;
		cyc((F + 1) * T + 6);
		chk_bit(st.power_enable_a, is_b);
		chk_bit(st.power_enable_b, !is_b);
		chk_bit(st.safe_torque_removal && !st.run_enable, 1'b1);
		chk_bit(st.mismatch, 1'b1);
		ack_pulse();
		chk_bit(st.ack_refused, 1'b1);
		cyc(40);
		en_a = 1'b1;
		en_b = 1'b1;
		cyc(10);
		chk_bit(st.fault_latched, 1'b0);
		chk_bit(st.mismatch, 1'b0);
	endtask
	task automatic t_latch();
		int i;
		en_b = 1'b0;
		for (i = 0; i < 120 && st.fault_latched !== 1'b1; i++) cyc(1);
		chk_bit(st.fault_latched, 1'b1);
		if (i >= 120) begin
			timed_out = 1'b1;
			return;
		end
		// must not latch before the full limit of disagreement has passed
		chk_bit(i > L * T, 1'b1);
		cyc(30);
		en_b = 1'b1;
		ack_pulse();
		chk_bit(st.ack_refused, 1'b1);
		cyc(5);
		chk_bit(st.fault_latched && !st.power_enable_a, 1'b1);
	endtask
	task automatic t_intf();
		i_rst = 1'b1;
		cyc(16);
		i_rst = 1'b0;
		cyc(6);
		flt = 1'b1;
		cyc(3);
		chk_bit(st.fault_latched && !st.power_enable_b, 1'b1);
		flt = 1'b0;
	endtask
	initial begin
		cyc(16);
		i_rst = 1'b0;
		cyc(2);
		t_run();
		t_single(1'b0);
		t_single(1'b1);
		t_latch();
		if (!timed_out) begin
			t_intf();
		end
		summarize();
	end
endmodule
`default_nettype wire
